// file: verilog/rxf_consts.vh
// register offsets, field positions and reset values of the receive fifo register bank
`ifndef RXF_CONSTS_VH
`define RXF_CONSTS_VH
`define RXF_OFF_FIFO_SEL     8'h00
`define RXF_OFF_A_READ_IDX   8'h04
`define RXF_OFF_B_READ_IDX   8'h08
`define RXF_OFF_MID_VAL      8'h0c
`define RXF_OFF_MID_MSK      8'h10
`define RXF_OFF_FID_VAL      8'h14
`define RXF_OFF_FID_MSK      8'h18
`define RXF_OFF_RNG_CFG      8'h1c
`define RXF_OFF_RNG_CTL      8'h20
`define RXF_OFF_FIFO_GEOM    8'h24
`define RXF_OFF_FLAG_WR      8'h28
`define RXF_BIT_WSCOPE       15
`define RXF_BIT_BSEL         14
`define RXF_SEL_HI           13
`define RXF_SEL_LO           12
`define RXF_SID_HI           10
`define RXF_MODE_LO          8
`define RXF_FLAG_A_BIT       0
`define RXF_FLAG_B_BIT       1
`define RXF_GEOM_DEPTH_LO    8
`define RXF_GEOM_DEPTH_HI    15
`define RXF_ZERO8            8'h00
`define RXF_ZERO11           11'h000
`define RXF_ZERO16           16'h0000
`define RXF_ZERO32           32'h00000000
`define RXF_ONE8             8'h01
`define RXF_RESP_OKAY        2'b00
`define RXF_RESP_SLVERR      2'b10
`endif

// file: verilog/rxf_read_ptr.v
// wrapping read pointer of one receive fifo
`include "rxf_consts.vh"
`default_nettype none
module rxf_read_ptr
(
   input  wire       clk,       // system clock
   input  wire       rst,       // synchronous reset
   input  wire [7:0] start_idx, // first header index of the fifo
   input  wire [7:0] depth,     // number of fifo entries
   input  wire       load,      // reload pointer from start index
   input  wire       advance,   // host acknowledged one entry
   output reg  [7:0] ptr_q      // header index of next entry
);
   reg  [7:0] ptr_d;
   wire [7:0] last_idx;
   assign last_idx = start_idx + depth - `RXF_ONE8;
   always @*
   begin
      ptr_d = ptr_q;
      if (load)
         ptr_d = start_idx;
      else if (advance)
      begin
         if (ptr_q == last_idx || depth == `RXF_ZERO8)
            ptr_d = start_idx;
         else
            ptr_d = ptr_q + `RXF_ONE8;
      end
   end
   always @(posedge clk)
   begin
      if (rst)
         ptr_q <= `RXF_ZERO8;
      else
         ptr_q <= ptr_d;
   end
endmodule
`default_nettype wire

// file: verilog/rxf_mask_match.v
// masked identifier comparison
`include "rxf_consts.vh"
`default_nettype none
module rxf_mask_match
(
   input  wire [15:0] ident,   // identifier under test
   input  wire [15:0] value,   // filter value
   input  wire [15:0] mask,    // filter mask, 1 = compare
   output wire        hit      // identifier matches
);
   assign hit = ((ident ^ value) & mask) == `RXF_ZERO16;
endmodule
`default_nettype wire

// file: verilog/rxf_regs.v
// receive fifo read index and filter register bank with axi4-lite slave
`include "rxf_consts.vh"
`default_nettype none
module rxf_regs
(
   input  wire        core_clk,      // system clock
   input  wire        rst,           // synchronous reset, active high
   input  wire [7:0]  s_axi_awaddr,  // write address
   input  wire        s_axi_awvalid, // write address valid
   output reg         s_axi_awready, // write address ready
   input  wire [31:0] s_axi_wdata,   // write data
   input  wire [3:0]  s_axi_wstrb,   // write byte strobes
   input  wire        s_axi_wvalid,  // write data valid
   output reg         s_axi_wready,  // write data ready
   output reg  [1:0]  s_axi_bresp,   // write response
   output reg         s_axi_bvalid,  // write response valid
   input  wire        s_axi_bready,  // write response ready
   input  wire [7:0]  s_axi_araddr,  // read address
   input  wire        s_axi_arvalid, // read address valid
   output reg         s_axi_arready, // read address ready
   output reg  [31:0] s_axi_rdata,   // read data
   output reg  [1:0]  s_axi_rresp,   // read response
   output reg         s_axi_rvalid,  // read response valid
   input  wire        s_axi_rready,  // read response ready
   input  wire [15:0] msg_id,        // message id to test
   input  wire [10:0] frame_id,      // frame id to test
   output reg         msgid_hit_q,   // message id accepted, selected fifo
   output reg         frameid_rej_q, // frame id rejected, selected fifo
   output reg  [3:0]  range_hit_q    // frame id inside range n, enabled only
);
   // write address / data capture
   reg        aw_have_q;
   reg [7:0]  aw_addr_q;
   reg        w_have_q;
   reg [31:0] w_data_q;
   reg [3:0]  w_strb_q;
   // registers
   reg        fifo_sel_q;
   reg [15:0] geom_q [0:1];
   reg [15:0] mid_val_q [0:1];
   reg [15:0] mid_msk_q [0:1];
   reg [10:0] fid_val_q [0:1];
   reg [10:0] fid_msk_q [0:1];
   reg [15:0] rng_cfg_q [0:1];
   reg [7:0]  rng_ctl_q [0:1];
   reg [10:0] lo_bound_q [0:7];
   reg [10:0] hi_bound_q [0:7];
   wire [7:0] ptr_a;
   wire [7:0] ptr_b;
   wire       wr_go;
   wire       rd_go;
   wire [31:0] wd;
   wire [2:0] bidx;
   wire       mid_hit;
   wire       fid_hit;
   wire [31:0] geom_m;
   wire [31:0] mid_val_m;
   wire [31:0] mid_msk_m;
   wire [31:0] fid_val_m;
   wire [31:0] fid_msk_m;
   reg  [1:0] geom_load_q;
   integer    i;
   integer    j;

   // byte-lane merge of old word and new data
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
   endfunction

   // offset decode, used by write and read paths
   function mapped;
      input [7:0] a;
      begin
         case (a)
            `RXF_OFF_FIFO_SEL, `RXF_OFF_A_READ_IDX, `RXF_OFF_B_READ_IDX,
            `RXF_OFF_MID_VAL, `RXF_OFF_MID_MSK, `RXF_OFF_FID_VAL,
            `RXF_OFF_FID_MSK, `RXF_OFF_RNG_CFG, `RXF_OFF_RNG_CTL,
            `RXF_OFF_FIFO_GEOM, `RXF_OFF_FLAG_WR:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign wd    = w_data_q;
   assign bidx  = {fifo_sel_q, wd[`RXF_SEL_HI:`RXF_SEL_LO]};

   // new register words after byte-lane merge
   assign geom_m    = merge({16'h0000, geom_q[fifo_sel_q]}, wd, w_strb_q);
   assign mid_val_m = merge({16'h0000, mid_val_q[fifo_sel_q]}, wd, w_strb_q);
   assign mid_msk_m = merge({16'h0000, mid_msk_q[fifo_sel_q]}, wd, w_strb_q);
   assign fid_val_m = merge({21'h000000, fid_val_q[fifo_sel_q]}, wd, w_strb_q);
   assign fid_msk_m = merge({21'h000000, fid_msk_q[fifo_sel_q]}, wd, w_strb_q);

   // pointer reload waits one cycle so it sees the new start index
   always @(posedge core_clk)
   begin
      if (rst)
         geom_load_q <= 2'b00;
      else
      begin
         geom_load_q[0] <= wr_go && aw_addr_q == `RXF_OFF_FIFO_GEOM && !fifo_sel_q;
         geom_load_q[1] <= wr_go && aw_addr_q == `RXF_OFF_FIFO_GEOM && fifo_sel_q;
      end
   end

   rxf_read_ptr u_ptr_a
   (
      .clk       (core_clk),
      .rst       (rst),
      .start_idx (geom_q[0][7:0]),
      .depth     (geom_q[0][`RXF_GEOM_DEPTH_HI:`RXF_GEOM_DEPTH_LO]),
      .load      (geom_load_q[0]),
      .advance   (wr_go && aw_addr_q == `RXF_OFF_FLAG_WR && w_strb_q[0]
                  && wd[`RXF_FLAG_A_BIT]),
      .ptr_q     (ptr_a)
   );

   rxf_read_ptr u_ptr_b
   (
      .clk       (core_clk),
      .rst       (rst),
      .start_idx (geom_q[1][7:0]),
      .depth     (geom_q[1][`RXF_GEOM_DEPTH_HI:`RXF_GEOM_DEPTH_LO]),
      .load      (geom_load_q[1]),
      .advance   (wr_go && aw_addr_q == `RXF_OFF_FLAG_WR && w_strb_q[0]
                  && wd[`RXF_FLAG_B_BIT]),
      .ptr_q     (ptr_b)
   );

   rxf_mask_match u_mid
   (
      .ident (msg_id),
      .value (mid_val_q[fifo_sel_q]),
      .mask  (mid_msk_q[fifo_sel_q]),
      .hit   (mid_hit)
   );

   rxf_mask_match u_fid
   (
      .ident ({5'h00, frame_id}),
      .value ({5'h00, fid_val_q[fifo_sel_q]}),
      .mask  ({5'h00, fid_msk_q[fifo_sel_q]}),
      .hit   (fid_hit)
   );

   // axi handshakes
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= `RXF_ZERO8;
         w_have_q      <= 1'b0;
         w_data_q      <= `RXF_ZERO32;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RXF_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rresp   <= `RXF_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(aw_addr_q) ? `RXF_RESP_OKAY : `RXF_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? `RXF_RESP_OKAY : `RXF_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // register writes
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         fifo_sel_q <= 1'b0;
         for (i = 0; i < 2; i = i + 1)
         begin
            geom_q[i]    <= `RXF_ZERO16;
            mid_val_q[i] <= `RXF_ZERO16;
            mid_msk_q[i] <= `RXF_ZERO16;
            fid_val_q[i] <= `RXF_ZERO11;
            fid_msk_q[i] <= `RXF_ZERO11;
            rng_cfg_q[i] <= `RXF_ZERO16;
            rng_ctl_q[i] <= `RXF_ZERO8;
         end
         for (i = 0; i < 8; i = i + 1)
         begin
            lo_bound_q[i] <= `RXF_ZERO11;
            hi_bound_q[i] <= `RXF_ZERO11;
         end
      end
      else if (wr_go)
      begin
         case (aw_addr_q)
            `RXF_OFF_FIFO_SEL:
               if (w_strb_q[0])
                  fifo_sel_q <= wd[0];
            `RXF_OFF_FIFO_GEOM:
               geom_q[fifo_sel_q] <= geom_m[15:0];
            `RXF_OFF_MID_VAL:
               mid_val_q[fifo_sel_q] <= mid_val_m[15:0];
            `RXF_OFF_MID_MSK:
               mid_msk_q[fifo_sel_q] <= mid_msk_m[15:0];
            `RXF_OFF_FID_VAL:
               fid_val_q[fifo_sel_q] <= fid_val_m[`RXF_SID_HI:0];
            `RXF_OFF_FID_MSK:
               fid_msk_q[fifo_sel_q] <= fid_msk_m[`RXF_SID_HI:0];
            `RXF_OFF_RNG_CFG:
               if (w_strb_q[1])
               begin
                  rng_cfg_q[fifo_sel_q] <= {wd[15:12], 1'b0, wd[10:0]};
                  if (!wd[`RXF_BIT_WSCOPE] && w_strb_q[0])
                  begin
                     if (wd[`RXF_BIT_BSEL])
                        hi_bound_q[bidx] <= wd[`RXF_SID_HI:0];
                     else
                        lo_bound_q[bidx] <= wd[`RXF_SID_HI:0];
                  end
               end
            `RXF_OFF_RNG_CTL:
               rng_ctl_q[fifo_sel_q] <= {wd[11:8] & {4{w_strb_q[1]}},
                                         wd[3:0] & {4{w_strb_q[0]}}} |
                                        {rng_ctl_q[fifo_sel_q][7:4] & {4{!w_strb_q[1]}},
                                         rng_ctl_q[fifo_sel_q][3:0] & {4{!w_strb_q[0]}}};
            default:
               fifo_sel_q <= fifo_sel_q;
         endcase
      end
   end

   // read data
   always @(posedge core_clk)
   begin
      if (rst)
         s_axi_rdata <= `RXF_ZERO32;
      else if (rd_go)
      begin
         case (s_axi_araddr)
            `RXF_OFF_FIFO_SEL:   s_axi_rdata <= {31'h00000000, fifo_sel_q};
            `RXF_OFF_A_READ_IDX: s_axi_rdata <= {24'h000000, ptr_a};
            `RXF_OFF_B_READ_IDX: s_axi_rdata <= {24'h000000, ptr_b};
            `RXF_OFF_MID_VAL:    s_axi_rdata <= {16'h0000, mid_val_q[fifo_sel_q]};
            `RXF_OFF_MID_MSK:    s_axi_rdata <= {16'h0000, mid_msk_q[fifo_sel_q]};
            `RXF_OFF_FID_VAL:    s_axi_rdata <= {21'h000000, fid_val_q[fifo_sel_q]};
            `RXF_OFF_FID_MSK:    s_axi_rdata <= {21'h000000, fid_msk_q[fifo_sel_q]};
            `RXF_OFF_RNG_CFG:
               s_axi_rdata <= {16'h0000, rng_cfg_q[fifo_sel_q][15:11],
                               rng_cfg_q[fifo_sel_q][14] ?
                               hi_bound_q[{fifo_sel_q, rng_cfg_q[fifo_sel_q][13:12]}] :
                               lo_bound_q[{fifo_sel_q, rng_cfg_q[fifo_sel_q][13:12]}]};
            `RXF_OFF_RNG_CTL:
               s_axi_rdata <= {20'h00000, rng_ctl_q[fifo_sel_q][7:4], 4'h0,
                               rng_ctl_q[fifo_sel_q][3:0]};
            `RXF_OFF_FIFO_GEOM:  s_axi_rdata <= {16'h0000, geom_q[fifo_sel_q]};
            default:             s_axi_rdata <= `RXF_ZERO32;
         endcase
      end
   end

   // filter results for the selected fifo
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         msgid_hit_q   <= 1'b0;
         frameid_rej_q <= 1'b0;
         range_hit_q   <= 4'h0;
      end
      else
      begin
         msgid_hit_q   <= mid_hit;
         frameid_rej_q <= fid_hit;
         for (j = 0; j < 4; j = j + 1)
            range_hit_q[j] <= rng_ctl_q[fifo_sel_q][j]
                              && frame_id >= lo_bound_q[{fifo_sel_q, j[1:0]}]
                              && frame_id <= hi_bound_q[{fifo_sel_q, j[1:0]}];
      end
   end
endmodule
`default_nettype wire

// file: dv/rxf_regs_props.sv
// handshake and filter output assertions for the receive fifo bank
`default_nettype none
module rxf_regs_props
(
   input wire logic        core_clk,      // system clock
   input wire logic        rst,           // synchronous reset
   input wire logic [7:0]  s_axi_awaddr,  // write address
   input wire logic        s_axi_awvalid, // write address valid
   input wire logic        s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata,   // write data
   input wire logic [3:0]  s_axi_wstrb,   // write byte strobes
   input wire logic        s_axi_wvalid,  // write data valid
   input wire logic        s_axi_wready,  // write data ready
   input wire logic [1:0]  s_axi_bresp,   // write response
   input wire logic        s_axi_bvalid,  // write response valid
   input wire logic        s_axi_bready,  // write response ready
   input wire logic [7:0]  s_axi_araddr,  // read address
   input wire logic        s_axi_arvalid, // read address valid
   input wire logic        s_axi_arready, // read address ready
   input wire logic [31:0] s_axi_rdata,   // read data
   input wire logic [1:0]  s_axi_rresp,   // read response
   input wire logic        s_axi_rvalid,  // read response valid
   input wire logic        s_axi_rready,  // read response ready
   input wire logic [15:0] msg_id,        // message id under test
   input wire logic [10:0] frame_id,      // frame id under test
   input wire logic        msgid_hit_q,   // message id accepted
   input wire logic        frameid_rej_q, // frame id rejected
   input wire logic [3:0]  range_hit_q    // range filter hits
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready too long");
   w_cause_a: assert property (s_axi_wready |-> s_axi_wvalid)
      else $error("wready without wvalid");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   wr_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write not answered");
   rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   err_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 0)
      else $error("error read has data");
   rng_reset_a: assert property ($past(rst) |-> range_hit_q == 4'h0)
      else $error("range hit after reset");
   hit_hold_a: assert property (
      (!s_axi_wvalid && !s_axi_bvalid && $stable(msg_id) && $stable(frame_id))[*3]
      |=> $stable(msgid_hit_q) && $stable(frameid_rej_q) && $stable(range_hit_q))
      else $error("filter output moved");
endmodule
bind rxf_regs rxf_regs_props u_props (.*);
`default_nettype wire

// file: dv/rxf_host_model.sv
// axi4-lite host issuing single register reads and writes
`default_nettype none
module rxf_host_model
(
   input  wire logic        core_clk,      // system clock
   input  wire logic        s_axi_awready, // write address ready
   input  wire logic        s_axi_wready,  // write data ready
   input  wire logic        s_axi_bvalid,  // write response valid
   input  wire logic        s_axi_arready, // read address ready
   input  wire logic        s_axi_rvalid,  // read response valid
   input  wire logic [1:0]  s_axi_bresp,   // write response
   input  wire logic [1:0]  s_axi_rresp,   // read response
   input  wire logic [31:0] s_axi_rdata,   // read data
   output var  logic [7:0]  s_axi_awaddr,  // write address
   output var  logic [7:0]  s_axi_araddr,  // read address
   output var  logic [31:0] s_axi_wdata,   // write data
   output var  logic [3:0]  s_axi_wstrb,   // write byte strobes
   output var  logic        s_axi_awvalid, // write address valid
   output var  logic        s_axi_wvalid,  // write data valid
   output var  logic        s_axi_bready,  // write response ready
   output var  logic        s_axi_arvalid, // read address valid
   output var  logic        s_axi_rready   // read response ready
);
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      @(posedge core_clk);
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      while (!(aw_ok && w_ok))
      begin
         @(posedge core_clk);
         aw_ok = aw_ok | s_axi_awready;
         w_ok = w_ok | s_axi_wready;
         s_axi_awvalid <= !aw_ok;
         s_axi_wvalid <= !w_ok;
      end
      // released data no longer valid
      s_axi_wdata <= ~d;
      while (!s_axi_bvalid)
         @(posedge core_clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do
         @(posedge core_clk);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid)
         @(posedge core_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: dv/rxf_regs_tb.sv
// self-checking bench for the receive fifo register bank
`default_nettype none
`include "rxf_consts.vh"
module rxf_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, msgid_hit_q, frameid_rej_q;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb, range_hit_q;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [15:0] msg_id;
   logic [10:0] frame_id;
   int          error_cnt, n_tests;
   rxf_regs uut (.*);
   rxf_host_model host (.*);
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      host.wr(a, d, rr);
      chk("bresp", `RXF_RESP_OKAY, rr);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
      host.rd(a, rv, rr);
      chk(nm, e, rv);
      chk("rresp", `RXF_RESP_OKAY, rr);
   endtask
   // drive identifiers, outputs follow one cycle later
   task automatic flt(input logic [15:0] m, input logic [10:0] f, input logic [5:0] e);
      msg_id <= m;
      frame_id <= f;
      repeat (2) @(posedge core_clk);
      chk("filter", e, {msgid_hit_q, frameid_rej_q, range_hit_q});
   endtask
   task automatic t_reset;
      for (int i = 0; i < 10; i++)
         rchk(8'(4 * i), 32'h0, "reset");
      host.rd(8'h40, rv, rr);
      chk("rd err", `RXF_RESP_SLVERR, rr);
      chk("rd data", 32'h0, rv);
      host.wr(8'h40, 32'h1, rr);
      chk("wr err", `RXF_RESP_SLVERR, rr);
   endtask
   task automatic t_filt;
      for (int f = 0; f < 2; f++)
      begin
         w(`RXF_OFF_FIFO_SEL, f);
         w(`RXF_OFF_MID_VAL, 32'hffff1234 + 32'h100 * f);
         w(`RXF_OFF_MID_MSK, 32'hffffff00);
         w(`RXF_OFF_FID_VAL, 32'hfffff055 + 32'h100 * f);
         w(`RXF_OFF_FID_MSK, 32'hfffff70f);
      end
      for (int f = 0; f < 2; f++)
      begin
         w(`RXF_OFF_FIFO_SEL, f);
         rchk(`RXF_OFF_MID_VAL, 32'h1234 + 32'h100 * f, "mid val");
         rchk(`RXF_OFF_MID_MSK, 32'hff00, "mid msk");
         rchk(`RXF_OFF_FID_VAL, 32'h055 + 32'h100 * f, "fid val");
         rchk(`RXF_OFF_FID_MSK, 32'h70f, "fid msk");
      end
      flt(16'h13aa, 11'h1a5, 6'b110000);
      flt(16'h12aa, 11'h1a4, 6'b000000);
   endtask
   task automatic t_range;
      for (int n = 0; n < 4; n++)
      begin
         w(`RXF_OFF_RNG_CFG, 32'h1000 * n + 16 * n + 4);
         w(`RXF_OFF_RNG_CFG, 32'h4000 + 32'h1000 * n + 16 * n + 8);
      end
      w(`RXF_OFF_RNG_CTL, 32'h0a0f);
      rchk(`RXF_OFF_RNG_CTL, 32'h0a0f, "ctl");
      flt(16'h0, 11'd38, 6'b000100);
      flt(16'h0, 11'd4, 6'b000001);
      flt(16'h0, 11'd40, 6'b000100);
      flt(16'h0, 11'd9, 6'b000000);
      w(`RXF_OFF_RNG_CFG, 32'he7ff);
      host.rd(`RXF_OFF_RNG_CFG, rv, rr);
      chk("cfg", 32'h6028, rv & 32'h7fff);
      flt(16'h0, 11'd41, 6'b000000);
      w(`RXF_OFF_RNG_CTL, 32'h0a0b);
      flt(16'h0, 11'd38, 6'b000000);
   endtask
   task automatic t_ptr;
      w(`RXF_OFF_FIFO_SEL, 1);
      w(`RXF_OFF_FIFO_GEOM, 32'h0305);
      w(`RXF_OFF_FIFO_SEL, 0);
      w(`RXF_OFF_FIFO_GEOM, 32'h0210);
      for (int i = 0; i < 4; i++)
      begin
         // entry index read before its flag is acknowledged
         rchk(`RXF_OFF_B_READ_IDX, 5 + i % 3, "b idx");
         w(`RXF_OFF_FLAG_WR, 32'h2);
      end
      // one fifo a entry acknowledged while flagged
      w(`RXF_OFF_FLAG_WR, 32'h1);
      rchk(`RXF_OFF_A_READ_IDX, 32'h11, "a idx");
      rchk(`RXF_OFF_B_READ_IDX, 32'h6, "b idx");
   endtask
   // reset in mid-run clears pointers and filter copies
   task automatic t_rerun;
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      rchk(`RXF_OFF_B_READ_IDX, 32'h0, "b idx rst");
      rchk(`RXF_OFF_A_READ_IDX, 32'h0, "a idx rst");
      rchk(`RXF_OFF_MID_VAL, 32'h0, "mid val rst");
   endtask
   task automatic test_done;
      if (error_cnt == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #60000;
      error_cnt++;
      test_done;
   end
   initial
   begin
      error_cnt = 0;
      n_tests = 0;
      rst = 1'b1;
      msg_id = 16'h0;
      frame_id = 11'h0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      t_reset;
      t_filt;
      t_range;
      t_ptr;
      t_rerun;
      test_done;
   end
endmodule
`default_nettype wire
